// ===== hdl/fault_alert_defines.svh
// Constants of the fault, alert and general pin register block.
// Assumes inclusion by bare name from any file that needs offsets or fields.
`ifndef FAULT_ALERT_DEFINES_SVH
`define FAULT_ALERT_DEFINES_SVH

// Command byte offsets
`define FA_OFS_FAULT_EN      8'h02
`define FA_OFS_THRESH_EN     8'h03
`define FA_OFS_FAULT_LOG     8'h04
`define FA_OFS_ALARM_LOG     8'h05
`define FA_OFS_BAD_TIMEOUT   8'h06
`define FA_OFS_PIN_CONFIG    8'h07
`define FA_OFS_THR_FIRST     8'h08
`define FA_OFS_THR_LAST      8'h0F

// Reset values
`define FA_RST_ZERO          8'h00
`define FA_RST_BAD_TIMEOUT   8'hFF
`define FA_RST_THR_MIN       8'h00
`define FA_RST_THR_MAX       8'hFF

// Fault log and fault enable bit positions
`define FA_BIT_NVM_DONE      7
`define FA_BIT_XBAD          6
`define FA_BIT_ON_PIN        4

// Pin configuration bit positions
`define FA_BIT_PIN3_PD       7
`define FA_BIT_PIN2_PD       6
`define FA_BIT_PIN1_SEL_HI   5
`define FA_BIT_PIN1_SEL_LO   4
`define FA_BIT_PIN1_VAL      3
`define FA_BIT_CONV_ALERT    2
`define FA_BIT_STRESS_PIN2   1
`define FA_BIT_OVF_ALERT     0

// Millisecond base for the transistor-bad wait
`define FA_MS_NS             1000000
`define FA_CLK_PERIOD_NS     4
`define FA_MS_CYCLES         (`FA_MS_NS / `FA_CLK_PERIOD_NS)

`endif

// ===== hdl/fault_alert_pkg.sv
// Types shared by the fault, alert and general pin register block.
// Assumes no other package; all users name items with the package scope.
package fault_alert_pkg;

    // Fault events, one bit per fault log position
    typedef struct packed {
        logic nvm_done;        // Nonvolatile write finished
        logic transistor_bad;  // Pass transistor bad, after wait
        logic transistor_short;// Converter saw a shorted transistor
        logic on_pin;          // On pin changed state
        logic power_bad;       // Power bad fault
        logic overcurrent;     // Overcurrent fault
        logic undervoltage;    // Undervoltage fault
        logic overvoltage;     // Overvoltage fault
    } fault_evt_t;

    // Converter results, index 0 pin voltage, 1 source, 2 sense, 3 power
    typedef logic [3:0][7:0] meas_t;

    // Function of general pin 1
    typedef enum logic [1:0] {
        PIN1_POWER_GOOD = 2'b00,
        PIN1_GEN_OUTPUT = 2'b01,
        PIN1_POWER_BAD  = 2'b10,
        PIN1_GEN_INPUT  = 2'b11
    } pin1_mode_t;

endpackage : fault_alert_pkg

// ===== hdl/fault_alert_gpio_regs.sv
// Fault logs, alert enables, transistor-bad wait and general pin control.
// Assumes event inputs are one-cycle pulses and levels synchronous to clock_i,
// and a command byte port from the serial host front end.
`timescale 1ns/1ps
`include "fault_alert_defines.svh"

// Behaviour
// RULE_01: Nonvolatile write done alerts when bit 7 enabled
// RULE_02: Fault enable bits 6..0 gate fault alerts
// RULE_03: Threshold enable pairs gate above/below alerts
// RULE_04: Nonvolatile write done sets fault log bit 7
// RULE_05: Fault events set fault log bits 6..0
// RULE_06: Threshold crossings set alarm log bits
// RULE_07: Transistor-bad wait in ms, zero disables
// RULE_08: Pins 3 and 2 pull low when bit set
// RULE_09: Pin 1 function selected by bits 5:4
// RULE_10: Conversion done alerts when bit 2 set
// RULE_11: Stress pulls pin 2 low when bit 1 set
// RULE_12: Meter or timer overflow alerts when bit 0
// RULE_13: Mask stops on pin clearing fault log
// RULE_14: Eight-bit min/max thresholds, defaults 00/FF
// RULE_15: Log bits sticky; event beats host clear
// RULE_16: Enabled events hold alert low until serviced
// RULE_17: Host reads logs and clears handled bits
module fault_alert_gpio_regs #(
    parameter int unsigned MS_CYCLES = `FA_MS_CYCLES   // Clock cycles in one millisecond
) (
    input  wire logic                        clock_i,             // System clock
    input  wire logic                        arst_n_i,            // Asynchronous reset, active low
    // Command byte register port
    input  wire logic [7:0]                  reg_addr_i,          // Command byte
    input  wire logic                        reg_wr_i,            // Write strobe
    input  wire logic [7:0]                  reg_wdata_i,         // Write data
    input  wire logic                        reg_rd_i,            // Read strobe
    output logic      [7:0]                  reg_rdata_o,         // Read data, one cycle after strobe
    // Events and conditions
    input  wire fault_alert_pkg::fault_evt_t fault_evt_i,         // Fault pulses; bad bit is ignored
    input  wire logic                        transistor_bad_i,    // Raw transistor-bad condition level
    input  wire logic                        on_fault_mask_i,     // Control register mask bit
    input  wire logic                        conv_done_i,         // Converter finished a measurement
    input  wire fault_alert_pkg::meas_t      meas_i,              // Results valid with conv_done_i
    input  wire logic                        meter_overflow_i,    // Energy or time counter overflow
    input  wire logic                        power_good_i,        // Power good level
    input  wire logic                        stress_i,            // Transistor under stress
    // Fault flag; pins open drain
    output logic                             transistor_bad_flag_o, // Transistor-bad fault declared
    output logic                             alert_n_o,           // Alert pin level driven
    output logic                             alert_oe_o,          // Alert pin pulled low
    output logic                             general_pin_1_o,     // Pin 1 level driven
    output logic                             general_pin_1_oe_o,  // Pin 1 pulled low
    output logic                             general_pin_2_o,     // Pin 2 level driven
    output logic                             general_pin_2_oe_o,  // Pin 2 pulled low
    output logic                             general_pin_3_o,     // Pin 3 level driven
    output logic                             general_pin_3_oe_o   // Pin 3 pulled low
);

    // Reset synchroniser
    logic                        rst_meta_q;  // First stage
    logic                        rst_n_q;     // Released reset used below

    // Registers
    logic [7:0]                  fault_en_q, fault_en_d;      // Fault alert enables
    logic [7:0]                  thresh_en_q, thresh_en_d;    // Threshold alert enables
    logic [7:0]                  fault_log_q, fault_log_d;    // Sticky fault log
    logic [7:0]                  alarm_log_q, alarm_log_d;    // Sticky alarm log
    logic [7:0]                  bad_wait_q, bad_wait_d;      // Transistor-bad wait in ms
    logic [7:0]                  pin_cfg_q, pin_cfg_d;        // General pin configuration
    logic [7:0]                  thr_q [8];                   // Min/max thresholds
    logic [7:0]                  thr_d [8];
    logic                        alert_q, alert_d;            // Pending alert
    logic [7:0]                  rdata_q, rdata_d;            // Read data

    // Transistor-bad timing
    logic [31:0]                 tick_q, tick_d;              // Cycles within a millisecond
    logic [7:0]                  ms_q, ms_d;                  // Elapsed milliseconds
    logic                        bad_q, bad_d;                // Fault declared

    // Pin drive
    logic                        pin1_oe_q, pin1_oe_d;
    logic                        pin2_oe_q, pin2_oe_d;
    logic                        pin3_oe_q, pin3_oe_d;

    // Combinational helpers
    logic [7:0]                  fault_set;     // Fault log bits to set
    logic [7:0]                  alarm_set;     // Alarm log bits to set
    logic                        bad_pulse;     // Fault declared this cycle
    logic                        alert_event;   // Any enabled event
    fault_alert_pkg::pin1_mode_t pin1_mode;     // Decoded pin 1 function

    // Two-flop release of the reset
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Transistor-bad wait: counts whole milliseconds while condition holds
    always_comb begin
        tick_d    = tick_q;
        ms_d      = ms_q;
        bad_d     = bad_q;
        bad_pulse = 1'b0;
        if (!transistor_bad_i || bad_wait_q == `FA_RST_ZERO) begin
            // Condition gone or fault disabled: restart
            tick_d = 32'h00000000;
            ms_d   = 8'h00;
            bad_d  = 1'b0; // RULE_07
        end else if (!bad_q) begin
            if (tick_q == MS_CYCLES - 1) begin
                // One millisecond elapsed
                tick_d = 32'h00000000;
                ms_d   = ms_q + 8'h01;
                if (ms_q + 8'h01 == bad_wait_q) begin
                    // Wait expired: declare once
                    bad_d     = 1'b1; // RULE_07
                    bad_pulse = 1'b1;
                end
            end else begin
                tick_d = tick_q + 32'h00000001;
            end
        end
    end

    // Event collection into log set masks
    always_comb begin
        fault_set = fault_evt_i;
        fault_set[`FA_BIT_XBAD] = bad_pulse; // RULE_05
        alarm_set = 8'h00;
        if (conv_done_i) begin
            // Compare each quantity with its thresholds
            for (int i = 0; i < 4; i++) begin
                alarm_set[2*i+1] = meas_i[i] > thr_q[2*i+1]; // RULE_06 RULE_14
                alarm_set[2*i]   = meas_i[i] < thr_q[2*i];   // RULE_06 RULE_14
            end
        end
        alert_event = |(fault_set & fault_en_q)                           // RULE_01 RULE_02
                    | |(alarm_set & thresh_en_q)                          // RULE_03
                    | (conv_done_i & pin_cfg_q[`FA_BIT_CONV_ALERT])       // RULE_10
                    | (meter_overflow_i & pin_cfg_q[`FA_BIT_OVF_ALERT]);  // RULE_12
    end

    // Register writes, sticky logs and alert state
    always_comb begin
        fault_en_d  = fault_en_q;
        thresh_en_d = thresh_en_q;
        fault_log_d = fault_log_q;
        alarm_log_d = alarm_log_q;
        bad_wait_d  = bad_wait_q;
        pin_cfg_d   = pin_cfg_q;
        thr_d       = thr_q;
        alert_d     = alert_q;
        rdata_d     = rdata_q;
        if (reg_wr_i) begin
            // Host write by command byte; unmapped bytes ignored
            unique case (reg_addr_i)
                `FA_OFS_FAULT_EN:    fault_en_d  = reg_wdata_i;
                `FA_OFS_THRESH_EN:   thresh_en_d = reg_wdata_i;
                `FA_OFS_FAULT_LOG: begin
                    fault_log_d = reg_wdata_i; // RULE_17
                    alert_d     = 1'b0;        // RULE_16
                end
                `FA_OFS_ALARM_LOG: begin
                    alarm_log_d = reg_wdata_i; // RULE_17
                    alert_d     = 1'b0;        // RULE_16
                end
                `FA_OFS_BAD_TIMEOUT: bad_wait_d  = reg_wdata_i; // RULE_07
                `FA_OFS_PIN_CONFIG:  pin_cfg_d   = reg_wdata_i;
                default: begin
                    // Threshold bytes
                    if (reg_addr_i >= `FA_OFS_THR_FIRST && reg_addr_i <= `FA_OFS_THR_LAST) begin
                        thr_d[reg_addr_i[2:0]] = reg_wdata_i; // RULE_14
                    end
                end
            endcase
        end
        if (fault_evt_i.on_pin && !on_fault_mask_i) begin
            // Unmasked on pin transition wipes the fault log
            fault_log_d = 8'h00; // RULE_13
        end
        // Events set after writes and clears, so a set always wins
        fault_log_d = fault_log_d | fault_set; // RULE_04 RULE_05 RULE_15
        alarm_log_d = alarm_log_d | alarm_set; // RULE_06 RULE_15
        if (alert_event) begin
            alert_d = 1'b1; // RULE_16
        end
        if (reg_rd_i) begin
            // Read mux; unmapped bytes read zero
            unique case (reg_addr_i)
                `FA_OFS_FAULT_EN:    rdata_d = fault_en_q;
                `FA_OFS_THRESH_EN:   rdata_d = thresh_en_q;
                `FA_OFS_FAULT_LOG:   rdata_d = fault_log_q;
                `FA_OFS_ALARM_LOG:   rdata_d = alarm_log_q;
                `FA_OFS_BAD_TIMEOUT: rdata_d = bad_wait_q;
                `FA_OFS_PIN_CONFIG:  rdata_d = pin_cfg_q;
                default: begin
                    if (reg_addr_i >= `FA_OFS_THR_FIRST && reg_addr_i <= `FA_OFS_THR_LAST) begin
                        rdata_d = thr_q[reg_addr_i[2:0]];
                    end else begin
                        rdata_d = 8'h00;
                    end
                end
            endcase
        end
    end

    // General pin drive, pull low when enable high
    always_comb begin
        pin1_mode = fault_alert_pkg::pin1_mode_t'(pin_cfg_q[`FA_BIT_PIN1_SEL_HI:`FA_BIT_PIN1_SEL_LO]);
        pin3_oe_d = pin_cfg_q[`FA_BIT_PIN3_PD]; // RULE_08
        pin2_oe_d = pin_cfg_q[`FA_BIT_PIN2_PD]                             // RULE_08
                  | (pin_cfg_q[`FA_BIT_STRESS_PIN2] & stress_i);          // RULE_11
        unique case (pin1_mode)
            // Released high while power is good
            fault_alert_pkg::PIN1_POWER_GOOD: pin1_oe_d = !power_good_i;   // RULE_09
            // Released high while power is bad
            fault_alert_pkg::PIN1_POWER_BAD:  pin1_oe_d = power_good_i;    // RULE_09
            // One releases, zero pulls low
            fault_alert_pkg::PIN1_GEN_OUTPUT: pin1_oe_d = !pin_cfg_q[`FA_BIT_PIN1_VAL]; // RULE_09
            // Input: never driven
            fault_alert_pkg::PIN1_GEN_INPUT:  pin1_oe_d = 1'b0;            // RULE_09
        endcase
    end

    // State registers
    always_ff @(posedge clock_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            fault_en_q  <= `FA_RST_ZERO;
            thresh_en_q <= `FA_RST_ZERO;
            fault_log_q <= `FA_RST_ZERO;
            alarm_log_q <= `FA_RST_ZERO;
            bad_wait_q  <= `FA_RST_BAD_TIMEOUT; // RULE_07
            pin_cfg_q   <= `FA_RST_ZERO;
            for (int i = 0; i < 8; i++) begin
                // Even bytes minimum, odd bytes maximum
                thr_q[i] <= i[0] ? `FA_RST_THR_MAX : `FA_RST_THR_MIN; // RULE_14
            end
            alert_q     <= 1'b0;
            rdata_q     <= 8'h00;
            tick_q      <= 32'h00000000;
            ms_q        <= 8'h00;
            bad_q       <= 1'b0;
            pin1_oe_q   <= 1'b0;
            pin2_oe_q   <= 1'b0;
            pin3_oe_q   <= 1'b0;
        end else begin
            fault_en_q  <= fault_en_d;
            thresh_en_q <= thresh_en_d;
            fault_log_q <= fault_log_d;
            alarm_log_q <= alarm_log_d;
            bad_wait_q  <= bad_wait_d;
            pin_cfg_q   <= pin_cfg_d;
            thr_q       <= thr_d;
            alert_q     <= alert_d;
            rdata_q     <= rdata_d;
            tick_q      <= tick_d;
            ms_q        <= ms_d;
            bad_q       <= bad_d;
            pin1_oe_q   <= pin1_oe_d;
            pin2_oe_q   <= pin2_oe_d;
            pin3_oe_q   <= pin3_oe_d;
        end
    end

    // Outputs; open-drain levels are always low, enables decide
    assign reg_rdata_o           = rdata_q;
    assign transistor_bad_flag_o = bad_q;
    assign alert_n_o             = 1'b0;
    assign alert_oe_o            = alert_q; // RULE_16
    assign general_pin_1_o       = 1'b0;
    assign general_pin_1_oe_o    = pin1_oe_q;
    assign general_pin_2_o       = 1'b0;
    assign general_pin_2_oe_o    = pin2_oe_q;
    assign general_pin_3_o       = 1'b0;
    assign general_pin_3_oe_o    = pin3_oe_q;

endmodule : fault_alert_gpio_regs

// ===== tb/fault_alert_gpio_regs_asserts.sv
// Port checks of the fault, alert and pin register block.
// Assumes binding to the block's top; shadows follow host writes.
`timescale 1ns/1ps
`include "fault_alert_defines.svh"
module fault_alert_gpio_regs_asserts #(
    parameter int unsigned MS_CYCLES = 4 // Cycles per millisecond
) (
    input wire logic                        clock_i,
    input wire logic                        arst_n_i,
    input wire logic [7:0]                  reg_addr_i,
    input wire logic                        reg_wr_i,
    input wire logic [7:0]                  reg_wdata_i,
    input wire logic                        reg_rd_i,
    input wire logic [7:0]                  reg_rdata_o,
    input wire fault_alert_pkg::fault_evt_t fault_evt_i,
    input wire logic                        transistor_bad_i,
    input wire logic                        conv_done_i,
    input wire logic                        meter_overflow_i,
    input wire logic                        power_good_i,
    input wire logic                        stress_i,
    input wire logic                        transistor_bad_flag_o,
    input wire logic                        alert_oe_o,
    input wire logic                        general_pin_1_oe_o,
    input wire logic                        general_pin_2_oe_o,
    input wire logic                        general_pin_3_oe_o
);
    logic [7:0]  en_q, en_d, cfg_q, cfg_d, to_q, to_d; // Enable, config, wait shadows
    logic [15:0] hi_q, hi_d, wait_c;                    // Cycles bad is high, wait length
    logic [2:0]  sync_q, sync_d;                        // Follows reset release
    logic        log_wr_c;                              // Host writes a log register
    // Next shadow values
    always_comb begin
        en_d     = (reg_wr_i && reg_addr_i == `FA_OFS_FAULT_EN) ? reg_wdata_i : en_q;
        cfg_d    = (reg_wr_i && reg_addr_i == `FA_OFS_PIN_CONFIG) ? reg_wdata_i : cfg_q;
        to_d     = (reg_wr_i && reg_addr_i == `FA_OFS_BAD_TIMEOUT) ? reg_wdata_i : to_q;
        hi_d     = transistor_bad_i ? hi_q + 16'h0001 : 16'h0000;
        sync_d   = {sync_q[1:0], 1'b1};
        wait_c   = 16'(to_q * MS_CYCLES);
        log_wr_c = reg_wr_i && (reg_addr_i == `FA_OFS_FAULT_LOG || reg_addr_i == `FA_OFS_ALARM_LOG);
    end
    // Shadow registers
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {en_q, cfg_q, to_q} <= {`FA_RST_ZERO, `FA_RST_ZERO, `FA_RST_BAD_TIMEOUT};
            {hi_q, sync_q} <= {16'h0000, 3'h0};
        end else begin
            {en_q, cfg_q, to_q, hi_q, sync_q} <= {en_d, cfg_d, to_d, hi_d, sync_d};
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!arst_n_i || !sync_q[2]);
    sequence cfg_write_s; reg_wr_i && reg_addr_i == `FA_OFS_PIN_CONFIG; endsequence
    sequence cfg_read_s; reg_rd_i && !reg_wr_i && reg_addr_i == `FA_OFS_PIN_CONFIG; endsequence
    unmapped_read_a: assert property (reg_rd_i && (reg_addr_i < 8'h02 || reg_addr_i > 8'h0F) |=>
        reg_rdata_o == 8'h00) else $error("Unmapped read not zero");
    cfg_readback_a: assert property (cfg_write_s ##2 cfg_read_s |=> reg_rdata_o == cfg_q)
        else $error("Config readback wrong");
    rdata_hold_a: assert property (!reg_rd_i |=> $stable(reg_rdata_o)) else $error("Read data moved");
    pin3_pull_a: assert property (general_pin_3_oe_o == $past(cfg_q[7])) else $error("Pin 3 pull wrong");
    pin2_pull_a: assert property (general_pin_2_oe_o == $past(cfg_q[6] | (cfg_q[1] & stress_i)))
        else $error("Pin 2 pull wrong");
    pin1_pull_a: assert property (general_pin_1_oe_o == $past(cfg_q[5:4] == 2'b00 ? !power_good_i :
        cfg_q[5:4] == 2'b10 ? power_good_i : cfg_q[5:4] == 2'b01 ? !cfg_q[3] : 1'b0)) else $error("Pin 1 wrong");
    alert_raise_a: assert property ((fault_evt_i & en_q & 8'hBF) != 8'h00 |=> alert_oe_o)
        else $error("Enabled fault gave no alert");
    aux_alert_a: assert property ((conv_done_i && cfg_q[2]) || (meter_overflow_i && cfg_q[0]) |=> alert_oe_o)
        else $error("Conversion or overflow gave no alert");
    alert_hold_a: assert property (alert_oe_o && !log_wr_c |=> alert_oe_o) else $error("Alert dropped");
    alert_clear_a: assert property (log_wr_c && fault_evt_i == 8'h00 && !conv_done_i && !meter_overflow_i
        && !en_q[6] |=> !alert_oe_o) else $error("Serviced alert stayed");
    bad_drop_a: assert property ((!transistor_bad_i || to_q == 8'h00) [*2] |=> !transistor_bad_flag_o)
        else $error("Bad flag stayed");
    bad_rise_a: assert property ($rose(transistor_bad_flag_o) |-> to_q != 8'h00 && hi_q >= wait_c
        && hi_q <= wait_c + 16'h0003) else $error("Bad flag wait wrong");
endmodule : fault_alert_gpio_regs_asserts

// ===== tb/reg_host_model.sv
// Serial host model: single-byte writes and reads on the command port.
// Assumes its tasks are entered just after a falling clock edge.
`timescale 1ns/1ps
module reg_host_model (
    input  wire logic       clock_i,     // System clock
    input  wire logic [7:0] reg_rdata_i, // Read data from the block
    output logic      [7:0] reg_addr_o,  // Command byte
    output logic            reg_wr_o,    // Write strobe
    output logic      [7:0] reg_wdata_o, // Write data
    output logic            reg_rd_o     // Read strobe
);
    // Idle bus at time zero
    initial begin
        {reg_addr_o, reg_wdata_o, reg_wr_o, reg_rd_o} = 18'h0;
    end
    // One-cycle write, one idle cycle; released lines inverted
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        {reg_addr_o, reg_wdata_o, reg_wr_o} = {a, d, 1'b1};
        @(negedge clock_i) {reg_addr_o, reg_wdata_o, reg_wr_o} = {~a, ~d, 1'b0};
        @(negedge clock_i);
    endtask : wr
    // One-cycle read, one idle cycle; data taken as it stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        {reg_addr_o, reg_rd_o} = {a, 1'b1};
        @(negedge clock_i) {reg_addr_o, reg_rd_o} = {~a, 1'b0};
        d = reg_rdata_i;
        @(negedge clock_i);
    endtask : rd
    // Read a log, then write zero over the whole log
    task automatic service(input logic [7:0] a, output logic [7:0] d);
        rd(a, d);
        wr(a, 8'h00);
    endtask : service
endmodule : reg_host_model

// ===== tb/tb_fault_alert_gpio_regs.sv
// Testbench of the fault, alert and pin register block.
// Assumes the checker and host model are compiled first.
`timescale 1ns/1ps
`include "fault_alert_defines.svh"
module tb_fault_alert_gpio_regs;
    localparam int unsigned MS = 4;              // Short millisecond
    logic                        clock_i = 1'b0;  // System clock
    logic                        arst_n_i;        // Reset, active low
    logic [7:0]                  addr, wdata, rdata, d, c; // Port, read value, config
    logic                        wr, rd, bad, mask, conv, ovf, pg, stress; // Strobes, conditions
    logic                        flag, alert, p1, p2, p3; // Observed pulls and flag
    fault_alert_pkg::fault_evt_t evt;             // Fault pulses
    fault_alert_pkg::meas_t      meas;            // Converter results
    int                          mismatches = 0, samples_checked = 0, i;
    always #2 clock_i = ~clock_i;
    fault_alert_gpio_regs #(.MS_CYCLES(MS)) u_dut (.clock_i, .arst_n_i, .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .fault_evt_i(evt), .transistor_bad_i(bad),
        .on_fault_mask_i(mask), .conv_done_i(conv), .meas_i(meas), .meter_overflow_i(ovf), .power_good_i(pg),
        .stress_i(stress), .transistor_bad_flag_o(flag), .alert_n_o(), .alert_oe_o(alert), .general_pin_1_o(),
        .general_pin_1_oe_o(p1), .general_pin_2_o(), .general_pin_2_oe_o(p2), .general_pin_3_o(),
        .general_pin_3_oe_o(p3));
    reg_host_model u_host (.clock_i, .reg_rdata_i(rdata), .reg_addr_o(addr), .reg_wr_o(wr),
        .reg_wdata_o(wdata), .reg_rd_o(rd));
    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // Read and compare
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] v;
        u_host.rd(a, v);
        chk(v, e);
    endtask : rc
    // Event pulses
    task automatic pulse(input logic [7:0] e, input logic cd, input logic ov);
        {evt, conv, ovf} = {e, cd, ov};
        @(negedge clock_i) {evt, conv, ovf} = 10'h000;
        @(negedge clock_i);
    endtask : pulse
    // Verdict and end of run
    task automatic give_verdict();
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict
    // Watchdog
    initial begin
        repeat (20000) @(posedge clock_i);
        mismatches++;
        give_verdict();
    end
    // Main sequence
    initial begin
        {arst_n_i, evt, bad, mask, conv, ovf, pg, stress, meas} = {10'h000, 5'h10, 32'h0};
        repeat (12) @(negedge clock_i);
        arst_n_i = 1'b1;
        repeat (4) @(negedge clock_i);
        for (i = 2; i < 16; i++) begin
            rc(8'(i), (i == 6 || (i > 7 && i % 2)) ? 8'hFF : 8'h00);
        end
        u_host.wr(8'h10, 8'hAA);
        rc(8'h10, 8'h00);
        rc(8'h01, 8'h00);
        for (i = 0; i < 8; i++) begin
            if (i != 6) begin
                u_host.wr(`FA_OFS_FAULT_EN, 8'(1 << i));
                pulse(8'(1 << i), 1'b0, 1'b0);
                repeat (3) @(negedge clock_i);
                chk(8'(alert), 8'h01);
                u_host.service(`FA_OFS_FAULT_LOG, d);
                chk(d, 8'(1 << i));
                chk(8'(alert), 8'h00);
                u_host.wr(`FA_OFS_FAULT_EN, ~8'(1 << i));
                pulse(8'(1 << i), 1'b0, 1'b0);
                chk(8'(alert), 8'h00);
                u_host.service(`FA_OFS_FAULT_LOG, d);
                chk(d, 8'(1 << i));
            end
        end
        u_host.wr(`FA_OFS_FAULT_EN, 8'h00);
        pulse(8'h01, 1'b0, 1'b0);
        pulse(8'h10, 1'b0, 1'b0);
        rc(`FA_OFS_FAULT_LOG, 8'h11);
        mask = 1'b0;
        pulse(8'h10, 1'b0, 1'b0);
        rc(`FA_OFS_FAULT_LOG, 8'h10);
        pulse(8'h04, 1'b0, 1'b0);
        repeat (3) @(negedge clock_i);
        rc(`FA_OFS_FAULT_LOG, 8'h14);
        evt = 8'h02;
        u_host.wr(`FA_OFS_FAULT_LOG, 8'h00);
        evt = 8'h00;
        rc(`FA_OFS_FAULT_LOG, 8'h02);
        u_host.wr(8'h0F, 8'h80);
        u_host.wr(8'h08, 8'h10);
        u_host.wr(8'h0A, 8'h20);
        u_host.wr(`FA_OFS_THRESH_EN, 8'h81);
        rc(`FA_OFS_THRESH_EN, 8'h81);
        rc(8'h0F, 8'h80);
        meas = {8'h80, 8'h80, 8'h20, 8'h10};
        pulse(8'h00, 1'b1, 1'b0);
        chk(8'(alert), 8'h00);
        rc(`FA_OFS_ALARM_LOG, 8'h00);
        meas = {8'h81, 8'h80, 8'h1F, 8'h0F};
        pulse(8'h00, 1'b1, 1'b0);
        chk(8'(alert), 8'h01);
        u_host.service(`FA_OFS_ALARM_LOG, d);
        chk(d, 8'h85);
        u_host.wr(`FA_OFS_THRESH_EN, 8'h00);
        for (i = 0; i < 2; i++) begin
            u_host.wr(`FA_OFS_PIN_CONFIG, i == 0 ? 8'h04 : 8'h01);
            rc(`FA_OFS_PIN_CONFIG, i == 0 ? 8'h04 : 8'h01);
            pulse(8'h00, i == 1, i == 0);
            chk(8'(alert), 8'h00);
            pulse(8'h00, i == 0, i == 1);
            chk(8'(alert), 8'h01);
            u_host.service(`FA_OFS_ALARM_LOG, d);
            chk(8'(alert), 8'h00);
        end
        for (i = 0; i < 256; i++) begin
            c = {i[4:1], i[0], 1'b0, i[5], 1'b0};
            u_host.wr(`FA_OFS_PIN_CONFIG, c);
            {pg, stress} = {i[6], i[7]};
            @(negedge clock_i);
            chk(8'(p3), 8'(c[7]));
            chk(8'(p2), 8'(c[6] | (c[1] & stress)));
            chk(8'(p1), 8'(c[5:4] == 2'b00 ? !pg : c[5:4] == 2'b10 ? pg : c[5:4] == 2'b01 ? !c[3] : 1'b0));
        end
        u_host.service(`FA_OFS_FAULT_LOG, d);
        u_host.wr(`FA_OFS_BAD_TIMEOUT, 8'h02);
        u_host.wr(`FA_OFS_FAULT_EN, 8'h40);
        rc(`FA_OFS_BAD_TIMEOUT, 8'h02);
        bad = 1'b1;
        repeat (6) @(negedge clock_i);
        chk(8'(flag), 8'h00);
        repeat (6) @(negedge clock_i);
        chk({6'h00, alert, flag}, 8'h03);
        bad = 1'b0;
        repeat (2) @(negedge clock_i);
        chk(8'(flag), 8'h00);
        u_host.service(`FA_OFS_FAULT_LOG, d);
        chk(d, 8'h40);
        u_host.wr(`FA_OFS_BAD_TIMEOUT, 8'h00);
        bad = 1'b1;
        repeat (20) @(negedge clock_i);
        chk(8'(flag), 8'h00);
        bad = 1'b0;
        rc(`FA_OFS_FAULT_LOG, 8'h00);
        give_verdict();
    end
endmodule : tb_fault_alert_gpio_regs
bind fault_alert_gpio_regs fault_alert_gpio_regs_asserts #(.MS_CYCLES(MS_CYCLES)) u_chk (.clock_i, .arst_n_i,
    .reg_addr_i, .reg_wr_i, .reg_wdata_i, .reg_rd_i, .reg_rdata_o, .fault_evt_i, .transistor_bad_i, .conv_done_i,
    .meter_overflow_i, .power_good_i, .stress_i, .transistor_bad_flag_o, .alert_oe_o, .general_pin_1_oe_o,
    .general_pin_2_oe_o, .general_pin_3_oe_o);
